// ---- core/dmw_map.svh ----
// Offsets, field positions, reset values and timing counts of the watchdog
// Contract
// - Timeout or windowed mode, never both
// - Timeout mode: key before counter expiry
// - Expiry or wrong key is a failure
// - Failure gives warm reset or interrupt
// - Comes up enabled in timeout mode
// - Windowed mode: key between lower, upper
// - Windowed miss or wrong key fails
// - Control bit picks interrupt over reset
`ifndef DMW_MAP_SVH
`define DMW_MAP_SVH
// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define DMW_OFF_CTRL 8'h00
`define DMW_OFF_UPPER 8'h04
`define DMW_OFF_LOWER 8'h08
`define DMW_OFF_KEY 8'h0c
`define DMW_OFF_STATUS 8'h10
`define DMW_OFF_COUNT 8'h14
// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define DMW_CTRL_WIN 0
`define DMW_CTRL_IRQ_SEL 1
`define DMW_STAT_FLAG 0
`define DMW_STAT_KEY 1
// ---------------------------------------------
// Widths, reset values, key
// ---------------------------------------------
`define DMW_CNT_W 16
`define DMW_UPPER_RST 16'hffff
`define DMW_LOWER_RST 16'h0000
`define DMW_SERVICE_KEY 16'h5aa5
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define DMW_CLK_NS 50
`define DMW_RST_PULSE_NS 1000
`define DMW_RST_PULSE_CYC ((`DMW_RST_PULSE_NS + `DMW_CLK_NS - 1) / `DMW_CLK_NS)
`endif

// ---- core/dmw_pkg.sv ----
// Types shared by the watchdog modules
package dmw_pkg;
   // Response sequencer states
   typedef enum logic [0:0] {RESP_IDLE, RESP_PULSE} dmw_resp_type;
   // Whole state of the top module
   typedef struct packed {
      logic win;              // Windowed mode selected
      logic irq_sel;          // Interrupt instead of reset
      logic [15:0] upper;     // Timeout or upper bound
      logic [15:0] lower;     // Lower bound
      logic flag;             // Sticky failure flag
      logic cause_key;        // Last failure was a bad key write
      dmw_resp_type resp;     // Reset pulse sequencer
      logic [7:0] pulse_cnt;  // Cycles left of reset pulse
      logic warm_rst;         // Warm reset request
      logic irq;              // Interrupt request
      logic [31:0] rdata;     // Read data
   } dmw_state_type;
   // State of the counter module
   typedef struct packed {
      logic [15:0] count;
   } dmw_cnt_state_type;
endpackage

// ---- core/dmw_counter.sv ----
// Saturating watchdog counter with synchronous restart
`timescale 1ns/1ns
module dmw_counter #(
   parameter int W = 16
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic clr,
   output logic [W-1:0] count
);
   import dmw_pkg::*;
   logic [W-1:0] cnt_reg;  // Current count
   logic [W-1:0] cnt_next; // Next count
   // ---------------------------------------------
   // Next count
   // ---------------------------------------------
   always_comb begin
      cnt_next = cnt_reg;
      if (clr) begin
         cnt_next = '0;
      end else if (cnt_reg != '1) begin
         // Saturate so a stalled block never wraps back into a window
         cnt_next = cnt_reg + W'(1);
      end
   end
   // ---------------------------------------------
   // Register
   // ---------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
      end else if (ce) begin
         cnt_reg <= cnt_next;
      end
   end
   assign count = cnt_reg;
endmodule // dmw_counter

// ---- core/dmw_top.sv ----
// Dual-mode internal watchdog with register port
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ns
`include "dmw_map.svh"
module dmw_top #(
   parameter logic [15:0] UPPER_RST = `DMW_UPPER_RST,
   parameter logic [15:0] SERVICE_KEY = `DMW_SERVICE_KEY
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic warm_rst_req,
   output logic cpu_irq
);
   import dmw_pkg::*;
   localparam logic [7:0] PULSE_CYC = 8'(`DMW_RST_PULSE_CYC);
   // ---------------------------------------------
   // Declarations
   // ---------------------------------------------
   dmw_state_type st_reg;   // Registered state
   dmw_state_type st_next;  // Next state
   logic [15:0] count;      // Watchdog count
   logic ctrl_wr;           // Control write
   logic key_wr;            // Key write
   logic key_ok;            // Key value matches
   logic early;             // Before lower bound
   logic expire;            // Counter reached upper bound
   logic fail;              // Failure detected this cycle
   logic restart;           // Counter restart
   // Address match, used by every decode below
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction
   // ---------------------------------------------
   // Counter
   // ---------------------------------------------
   dmw_counter #(.W(`DMW_CNT_W)) u_cnt (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .ce(ce),
      .clr(restart),
      .count(count)
   );
   // ---------------------------------------------
   // Failure detection
   // ---------------------------------------------
   always_comb begin
      ctrl_wr = wr && hit(addr, `DMW_OFF_CTRL);
      key_wr = wr && hit(addr, `DMW_OFF_KEY);
      key_ok = (wdata[15:0] == SERVICE_KEY);
      // Lower bound only matters in windowed mode
      early = st_reg.win && (count < st_reg.lower);
      // Same register serves as timeout and upper bound
      expire = (count >= st_reg.upper);
      fail = expire || (key_wr && (!key_ok || early));
      // Any key write or failure starts a new period; mode change too
      restart = fail || key_wr || ctrl_wr;
   end
   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.rdata = 32'h0;
      // Register writes
      if (ctrl_wr) begin
         // One bit picks the mode, so the two can never both run
         st_next.win = wdata[`DMW_CTRL_WIN];
         st_next.irq_sel = wdata[`DMW_CTRL_IRQ_SEL];
      end
      if (wr && hit(addr, `DMW_OFF_UPPER)) begin
         st_next.upper = wdata[15:0];
      end
      if (wr && hit(addr, `DMW_OFF_LOWER)) begin
         st_next.lower = wdata[15:0];
      end
      // Write one to clear; a new failure wins over the clear
      if (wr && hit(addr, `DMW_OFF_STATUS) && wdata[`DMW_STAT_FLAG]) begin
         st_next.flag = 1'b0;
         st_next.cause_key = 1'b0;
      end
      if (fail) begin
         st_next.flag = 1'b1;
         st_next.cause_key = key_wr;
      end
      // Reset pulse sequencer
      case (st_reg.resp)
         RESP_IDLE: begin
            if (fail && !st_next.irq_sel) begin
               st_next.resp = RESP_PULSE;
               st_next.pulse_cnt = PULSE_CYC;
            end
         end
         RESP_PULSE: begin
            if (st_reg.pulse_cnt <= 8'h01) begin
               st_next.resp = RESP_IDLE;
               st_next.pulse_cnt = 8'h00;
            end else begin
               st_next.pulse_cnt = st_reg.pulse_cnt - 8'h01;
            end
         end
         default: begin
            st_next.resp = RESP_IDLE;
         end
      endcase
      st_next.warm_rst = (st_next.resp == RESP_PULSE);
      // Interrupt is the sticky flag when interrupt response is picked
      st_next.irq = st_next.flag && st_next.irq_sel;
      // Read data, valid in the cycle after the strobe only
      if (rd) begin
         if (hit(addr, `DMW_OFF_CTRL)) begin
            st_next.rdata[`DMW_CTRL_WIN] = st_reg.win;
            st_next.rdata[`DMW_CTRL_IRQ_SEL] = st_reg.irq_sel;
         end else if (hit(addr, `DMW_OFF_UPPER)) begin
            st_next.rdata[15:0] = st_reg.upper;
         end else if (hit(addr, `DMW_OFF_LOWER)) begin
            st_next.rdata[15:0] = st_reg.lower;
         end else if (hit(addr, `DMW_OFF_STATUS)) begin
            st_next.rdata[`DMW_STAT_FLAG] = st_reg.flag;
            st_next.rdata[`DMW_STAT_KEY] = st_reg.cause_key;
         end else if (hit(addr, `DMW_OFF_COUNT)) begin
            st_next.rdata[15:0] = count;
         end
         // Key and unmapped offsets read as zero
      end
   end
   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         // Enabled in timeout mode with reset response, no software needed
         st_reg.win <= 1'b0;
         st_reg.irq_sel <= 1'b0;
         st_reg.upper <= UPPER_RST;
         st_reg.lower <= `DMW_LOWER_RST;
         st_reg.flag <= 1'b0;
         st_reg.cause_key <= 1'b0;
         st_reg.resp <= RESP_IDLE;
         st_reg.pulse_cnt <= 8'h00;
         st_reg.warm_rst <= 1'b0;
         st_reg.irq <= 1'b0;
         st_reg.rdata <= 32'h0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end
   assign rdata = st_reg.rdata;
   assign warm_rst_req = st_reg.warm_rst;
   assign cpu_irq = st_reg.irq;
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   property p_rst_mode;
      @(posedge clk_sys) $rose(arst_n) |-> !st_reg.win && !st_reg.irq_sel;
   endproperty
   a_rst_mode: assert property (p_rst_mode) else $error("not timeout mode after reset");
   property p_mode_sel;
      @(posedge clk_sys) disable iff (!arst_n)
         ce && ctrl_wr |=> st_reg.win == $past(wdata[`DMW_CTRL_WIN]);
   endproperty
   a_mode_sel: assert property (p_mode_sel) else $error("mode bit not taken");
   property p_expire;
      @(posedge clk_sys) disable iff (!arst_n)
         ce && count >= st_reg.upper |=> st_reg.flag && count == 16'h0000;
   endproperty
   a_expire: assert property (p_expire) else $error("expiry not flagged");
   property p_bad_key;
      @(posedge clk_sys) disable iff (!arst_n)
         ce && key_wr && wdata[15:0] != SERVICE_KEY |=> st_reg.flag && st_reg.cause_key;
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("wrong key not flagged");
   property p_early;
      @(posedge clk_sys) disable iff (!arst_n)
         ce && key_wr && st_reg.win && count < st_reg.lower |=> st_reg.flag;
   endproperty
   a_early: assert property (p_early) else $error("early key not flagged");
   property p_service;
      @(posedge clk_sys) disable iff (!arst_n)
         ce && key_wr && !fail
            |=> count == 16'h0000 && !st_reg.cause_key == !$past(st_reg.cause_key);
   endproperty
   a_service: assert property (p_service) else $error("good key did not restart");
   property p_irq_resp;
      @(posedge clk_sys) disable iff (!arst_n)
         ce && fail && st_reg.irq_sel && !ctrl_wr |=> cpu_irq && !$rose(warm_rst_req);
   endproperty
   a_irq_resp: assert property (p_irq_resp) else $error("interrupt response missing");
   // A failure in the last pulse cycle does not retrigger, so it is left out
   property p_rst_resp;
      @(posedge clk_sys) disable iff (!arst_n)
         ce && fail && !st_reg.irq_sel && !ctrl_wr && st_reg.pulse_cnt != 8'h01
            |=> warm_rst_req && !cpu_irq;
   endproperty
   a_rst_resp: assert property (p_rst_resp) else $error("reset response missing");
   property p_pulse_len;
      @(posedge clk_sys) disable iff (!arst_n)
         st_reg.pulse_cnt <= PULSE_CYC && (warm_rst_req == (st_reg.pulse_cnt != 8'h00));
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");
   // A reset-response failure while the sequencer is idle loads the full pulse length
   property p_pulse_start;
      @(posedge clk_sys) disable iff (!arst_n)
         ce && fail && !ctrl_wr && !st_reg.irq_sel && st_reg.resp == RESP_IDLE
            |=> st_reg.pulse_cnt == PULSE_CYC;
   endproperty
   a_pulse_start: assert property (p_pulse_start) else $error("pulse not loaded");
   // A good key inside the window restarts without touching the flag
   property p_in_window;
      @(posedge clk_sys) disable iff (!arst_n)
         ce && key_wr && key_ok && count >= st_reg.lower && count < st_reg.upper
            |=> count == 16'h0000 && st_reg.flag == $past(st_reg.flag);
   endproperty
   a_in_window: assert property (p_in_window) else $error("in-window key not accepted");
   // Clearing the flag drops the interrupt unless a new failure wins
   property p_clear;
      @(posedge clk_sys) disable iff (!arst_n)
         ce && wr && addr == `DMW_OFF_STATUS && wdata[`DMW_STAT_FLAG] && !fail
            |=> !st_reg.flag && !cpu_irq;
   endproperty
   a_clear: assert property (p_clear) else $error("flag clear not taken");
   // Clock enable low holds every register, counter included
   property p_freeze;
      @(posedge clk_sys) disable iff (!arst_n)
         !ce |=> $stable(st_reg) && $stable(count);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule // dmw_top

// ---- test/dmw_sys_reset_model.sv ----
// System reset logic model that measures warm reset pulses
`timescale 1ns/1ns
module dmw_sys_reset_model (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic warm_rst_req,
   output logic [7:0] last_len,
   output logic [7:0] pulse_cnt
);
   logic [7:0] run_reg; // Cycles seen in current pulse
   // ----------------------------------------
   // Pulse length and count
   // ----------------------------------------
   // Length is taken at the falling end, so a stuck request never reports
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         run_reg <= 8'h00;
         last_len <= 8'h00;
         pulse_cnt <= 8'h00;
      end else if (warm_rst_req) begin
         run_reg <= run_reg + 8'h01;
      end else if (run_reg != 8'h00) begin
         last_len <= run_reg;
         pulse_cnt <= pulse_cnt + 8'h01;
         run_reg <= 8'h00;
      end
   end
endmodule // dmw_sys_reset_model

// ---- test/testbench.sv ----
// Self-checking bench for the dual-mode watchdog
`timescale 1ns/1ns
`include "dmw_map.svh"
module testbench;
   logic clk_sys, arst_n, ce, wr, rd;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic warm_rst_req, cpu_irq;
   logic [7:0] last_len, pulse_cnt;
   int err_count, check_count;
   logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
   logic [31:0] rstv [6] = '{32'h0, 32'h40, 32'h0, 32'h0, 32'h0, 32'h0};
   // Short timeout keeps expiry runs brief
   dmw_top #(.UPPER_RST(16'h0040)) i_dmw_top (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .warm_rst_req(warm_rst_req), .cpu_irq(cpu_irq));
   dmw_sys_reset_model i_dmw_sys_reset_model (.clk_sys(clk_sys), .arst_n(arst_n),
      .warm_rst_req(warm_rst_req), .last_len(last_len), .pulse_cnt(pulse_cnt));
   // ----------------------------------------
   // Clock
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Compare with case equality so unknowns fail
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Bounded wait on an output: 1 picks cpu_irq, 0 picks warm_rst_req
   task automatic wait_out(input bit irq, input int lim);
      for (int i = 0; i <= lim; i++) begin
         @(posedge clk_sys);
         #1;
         if ((irq ? cpu_irq : warm_rst_req) === 1'b1) return;
      end
      err_count++;
      $display("unexpected at %0t: output never rose", $time);
      conclude();
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {arst_n, wr, rd, addr, wdata} = '0;
      ce = 1'b1;
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      // Reset values: timeout mode, reset response; unmapped place ignored
      wr_reg(8'h20, 32'hffff_ffff);
      for (int i = 0; i < 6; i++) begin
         rd_reg(offs[i]);
         chk(d, rstv[i], "reset value");
      end
      // Nobody services: expiry gives a 20-cycle warm reset
      wait_out(1'b0, 200);
      repeat (25) @(posedge clk_sys);
      chk({16'h0, last_len, pulse_cnt}, {16'h0, 8'd20, 8'd1}, "reset pulse");
      rd_reg(`DMW_OFF_STATUS);
      chk(d, 32'h1, "expiry flag");
      wr_reg(`DMW_OFF_STATUS, 32'h1);
      // Interrupt response, serviced in time several times
      wr_reg(`DMW_OFF_CTRL, 32'h2);
      for (int i = 0; i < 5; i++) begin
         repeat (40) @(posedge clk_sys);
         wr_reg(`DMW_OFF_KEY, {16'h0, `DMW_SERVICE_KEY});
      end
      rd_reg(`DMW_OFF_STATUS);
      chk(d, 32'h0, "serviced");
      chk({31'h0, cpu_irq}, 32'h0, "serviced irq");
      // Wrong key raises interrupt, not reset
      wr_reg(`DMW_OFF_KEY, 32'h1234);
      rd_reg(`DMW_OFF_STATUS);
      chk(d, 32'h3, "bad key status");
      chk({31'h0, cpu_irq}, 32'h1, "bad key irq");
      chk({24'h0, pulse_cnt}, 32'h1, "bad key no reset");
      wr_reg(`DMW_OFF_STATUS, 32'h1);
      rd_reg(`DMW_OFF_STATUS);
      chk(d, 32'h0, "flag cleared");
      chk({31'h0, cpu_irq}, 32'h0, "irq cleared");
      // Expiry with interrupt response
      wait_out(1'b1, 100);
      rd_reg(`DMW_OFF_STATUS);
      chk(d, 32'h1, "irq expiry");
      // Windowed mode by explicit configuration
      wr_reg(`DMW_OFF_LOWER, 32'h10);
      wr_reg(`DMW_OFF_UPPER, 32'h30);
      wr_reg(`DMW_OFF_STATUS, 32'h1);
      wr_reg(`DMW_OFF_CTRL, 32'h3);
      rd_reg(`DMW_OFF_CTRL);
      chk(d, 32'h3, "ctrl");
      // Key before the lower bound fails
      wr_reg(`DMW_OFF_KEY, {16'h0, `DMW_SERVICE_KEY});
      rd_reg(`DMW_OFF_STATUS);
      chk(d, 32'h3, "early key");
      wr_reg(`DMW_OFF_STATUS, 32'h1);
      // Key inside the window is accepted
      repeat (20) @(posedge clk_sys);
      wr_reg(`DMW_OFF_KEY, {16'h0, `DMW_SERVICE_KEY});
      rd_reg(`DMW_OFF_STATUS);
      chk(d, 32'h0, "in window");
      // Missed window raises interrupt
      wait_out(1'b1, 100);
      rd_reg(`DMW_OFF_STATUS);
      chk(d, 32'h1, "window miss");
      // Back to reset response: windowed miss gives warm reset
      wr_reg(`DMW_OFF_STATUS, 32'h1);
      wr_reg(`DMW_OFF_CTRL, 32'h1);
      wait_out(1'b0, 100);
      repeat (25) @(posedge clk_sys);
      chk({16'h0, last_len, pulse_cnt}, {16'h0, 8'd20, 8'd2}, "window reset");
      // Clock enable low for longer than the timeout: count holds, no expiry
      wr_reg(`DMW_OFF_CTRL, 32'h0);
      ce <= 1'b0;
      repeat (100) @(posedge clk_sys);
      ce <= 1'b1;
      rd_reg(`DMW_OFF_COUNT);
      chk(d, 32'h1, "count frozen");
      chk({24'h0, pulse_cnt}, 32'h2, "no reset while frozen");
      rd_reg(`DMW_OFF_CTRL);
      chk(d, 32'h0, "timeout mode again");
      // Reset in mid-run brings back timeout mode and reset values
      wr_reg(`DMW_OFF_CTRL, 32'h3);
      arst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rd_reg(offs[i]);
         chk(d, rstv[i], "value after reset");
      end
      conclude();
   end
endmodule // testbench
